// file: core/fcr_regs.sv
// Floating point control/status register bank with its enables alias.
`timescale 1ns/1ps
// Functional notes
// - Alias shares storage with full register.
// - Alias bits 31-12, 6-3 read zero.
// - Alias trap enables at bits 11-7.
// - Alias flush-to-zero at bit 2.
// - Alias rounding mode at bits 1-0.
// - Full register open to any enabled program.
// - Eight compare codes at 31-25 and 23.
// - Full register flush-to-zero at bit 24.
// - Flush override bit 22, nearest bit 21.
// - Fused mode reads zero, unfused only.
// - Fused mode concerns multiply-add family only.
// - Abs/neg NaN compliance reads one.
// - NaN encoding bit reads one.
// - Causes per instruction, sticky flags accumulate.
// - Trap when enable and cause both set.
// - Unimplemented cause always traps.
// - Flags set only untrapped, never hardware-cleared.
// - Round encoding nearest, zero, plus, minus.
module fcr_regs
    import fcr_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    input wire logic CLK_EN,
    input wire logic CP_ENABLE,
    input wire logic CTL_WR,
    input wire logic [4:0] CTL_IDX,
    input wire logic [31:0] CTL_WDATA,
    input wire logic [4:0] CTL_RIDX,
    output logic [31:0] CTL_RDATA,
    output logic CTL_DENIED,
    input wire logic ARITH_DONE,
    input wire logic [5:0] ARITH_EXC,
    input wire logic CMP_WR,
    input wire logic [2:0] CMP_SEL,
    input wire logic CMP_RESULT,
    output logic [7:0] COMPARE_CONDITION_CODES,
    output logic FLUSH_TO_ZERO,
    output logic FLUSH_OVERRIDE,
    output logic FLUSH_NEAREST,
    output logic FUSED_MADD_MODE,
    output logic [1:0] ROUND_SELECT,
    output logic FP_TRAP
);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic [7:0] cc_reg;
    logic fz_reg;
    logic fo_reg;
    logic fn_reg;
    logic [5:0] cause_reg;
    logic [4:0] en_reg;
    logic [4:0] flag_reg;
    logic [1:0] rnd_reg;
    logic [31:0] rdata_reg;
    logic denied_reg;

    logic wr_full;
    logic wr_alias;
    logic [31:0] full_view;
    logic [31:0] alias_view;
    logic [4:0] untrapped;
    logic [7:0] cc_next;

    fcr_ctl_if ctl ();

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    function automatic logic hit(input logic [4:0] idx,
                                 input logic [4:0] want);
        hit = (idx == want);
    endfunction

    // Full register bit that holds compare code n.
    function automatic int cc_pos(input int n);
        cc_pos = (n == 0) ? FCR_CC0 : FCR_CC_LO + n - 1;
    endfunction

    assign wr_full = CTL_WR && CP_ENABLE && hit(CTL_IDX, FCR_IDX_FULL);
    assign wr_alias = CTL_WR && CP_ENABLE && hit(CTL_IDX, FCR_IDX_ALIAS);

    // ----------------------------------------------------------------
    // Views
    // ----------------------------------------------------------------
    always_comb
    begin
        full_view = FCR_ZERO32;
        for (int n = 0; n < $bits(cc_reg); n++)
        begin
            full_view[cc_pos(n)] = cc_reg[n];
        end
        full_view[FCR_FLUSH_ZERO] = fz_reg;
        full_view[FCR_FLUSH_OVR] = fo_reg;
        full_view[FCR_FLUSH_NEAR] = fn_reg;
        full_view[FCR_FUSED] = FCR_FUSED_VAL;
        full_view[FCR_ABS_NAN] = FCR_ABS_NAN_VAL;
        full_view[FCR_NAN_ENC] = FCR_NAN_ENC_VAL;
        full_view[FCR_CAUSE_HI:FCR_CAUSE_LO] = cause_reg;
        full_view[FCR_EN_HI:FCR_EN_LO] = en_reg;
        full_view[FCR_FLAG_HI:FCR_FLAG_LO] = flag_reg;
        full_view[FCR_RND_HI:FCR_RND_LO] = rnd_reg;
    end

    always_comb
    begin
        alias_view = FCR_ZERO32;
        alias_view[FCR_EN_HI:FCR_EN_LO] = en_reg;
        alias_view[FCR_A_FLUSH_ZERO] = fz_reg;
        alias_view[FCR_RND_HI:FCR_RND_LO] = rnd_reg;
    end

    // ----------------------------------------------------------------
    // Shared fields, written from both views
    // ----------------------------------------------------------------
    // Only these three fields have a reset, because the alias view must
    // read zero after power-on while the rest of the full register need not.
    // one storage, two views
    always_ff @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            en_reg <= FCR_EN_RST;
            fz_reg <= FCR_FZ_RST;
            rnd_reg <= FCR_RND_RST;
        end
        else if (CLK_EN)
        begin
            if (wr_full)
            begin
                en_reg <= CTL_WDATA[FCR_EN_HI:FCR_EN_LO];
                fz_reg <= CTL_WDATA[FCR_FLUSH_ZERO];
                rnd_reg <= CTL_WDATA[FCR_RND_HI:FCR_RND_LO];
            end
            else if (wr_alias)
            begin
                en_reg <= CTL_WDATA[FCR_EN_HI:FCR_EN_LO];
                fz_reg <= CTL_WDATA[FCR_A_FLUSH_ZERO];
                rnd_reg <= CTL_WDATA[FCR_RND_HI:FCR_RND_LO];
            end
        end
    end

    // ----------------------------------------------------------------
    // Flush controls, unknown until software writes them
    // ----------------------------------------------------------------
    // No reset here: software must write the full register before it
    // relies on these bits, as it must for the causes and flags.
    always_ff @(posedge REF_CLK)
    begin
        if (CLK_EN && wr_full)
        begin
            fo_reg <= CTL_WDATA[FCR_FLUSH_OVR];
            fn_reg <= CTL_WDATA[FCR_FLUSH_NEAR];
        end
    end

    // ----------------------------------------------------------------
    // Compare condition codes
    // ----------------------------------------------------------------
    // compares write codes
    // A compare beats a software move to the same code, so the result of
    // the instruction is never lost to a concurrent register write.
    for (genvar n = 0; n < $bits(cc_reg); n++)
    begin : g_code
        assign cc_next[n] = (CMP_WR && int'(CMP_SEL) == n) ? CMP_RESULT :
            (wr_full ? CTL_WDATA[cc_pos(n)] : cc_reg[n]);
    end

    always_ff @(posedge REF_CLK)
    begin
        if (CLK_EN)
        begin
            cc_reg <= cc_next;
        end
    end

    // ----------------------------------------------------------------
    // Causes and sticky flags
    // ----------------------------------------------------------------
    // only untrapped exceptions
    assign untrapped = ARITH_EXC[FCR_E_UNIMPL-1:0] & ~en_reg;

    // An arithmetic result beats a software write of the cause field in
    // the same cycle, since the instruction completes after the move.
    // causes replaced per instruction
    always_ff @(posedge REF_CLK)
    begin
        if (CLK_EN)
        begin
            if (ARITH_DONE)
            begin
                cause_reg <= ARITH_EXC;
            end
            else if (wr_full)
            begin
                cause_reg <= CTL_WDATA[FCR_CAUSE_HI:FCR_CAUSE_LO];
            end
        end
    end

    // The hardware set is ORed in last, so a flag raised in the cycle of
    // a software clear survives it.
    // never hardware cleared
    always_ff @(posedge REF_CLK)
    begin
        if (CLK_EN)
        begin
            if (wr_full && ARITH_DONE)
            begin
                flag_reg <= CTL_WDATA[FCR_FLAG_HI:FCR_FLAG_LO] | untrapped;
            end
            else if (wr_full)
            begin
                flag_reg <= CTL_WDATA[FCR_FLAG_HI:FCR_FLAG_LO];
            end
            else if (ARITH_DONE)
            begin
                flag_reg <= flag_reg | untrapped;
            end
        end
    end

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    // Read data comes from a flop one cycle late; a denied or unknown
    // index returns zero rather than stale data.
    always_ff @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            rdata_reg <= FCR_ZERO32;
            denied_reg <= 1'b0;
        end
        else if (CLK_EN)
        begin
            denied_reg <= !CP_ENABLE;
            if (!CP_ENABLE)
            begin
                rdata_reg <= FCR_ZERO32;
            end
            else if (hit(CTL_RIDX, FCR_IDX_FULL))
            begin
                rdata_reg <= full_view;
            end
            else if (hit(CTL_RIDX, FCR_IDX_ALIAS))
            begin
                rdata_reg <= alias_view;
            end
            else
            begin
                rdata_reg <= FCR_ZERO32;
            end
        end
    end

    // ----------------------------------------------------------------
    // Trap and control outputs
    // ----------------------------------------------------------------
    // The trap is combinational from flops, so a software move that sets
    // a cause with its enable traps in the very next cycle.
    assign ctl.cause = cause_reg;
    assign ctl.enables = en_reg;

    fcr_trap_unit u_trap
    (
        .ctl(ctl.trapu)
    );

    assign FP_TRAP = ctl.trap;
    assign CTL_RDATA = rdata_reg;
    assign CTL_DENIED = denied_reg;
    assign COMPARE_CONDITION_CODES = cc_reg;
    assign FLUSH_TO_ZERO = fz_reg;
    assign FLUSH_OVERRIDE = fo_reg;
    assign FLUSH_NEAREST = fn_reg;
    assign FUSED_MADD_MODE = FCR_FUSED_VAL;
    assign ROUND_SELECT = rnd_reg;

endmodule

// file: core/fcr_pkg.sv
// Package of constants and types for the floating point control registers.
package fcr_pkg;

    // ----------------------------------------------------------------
    // Register indices on the control move port
    // ----------------------------------------------------------------
    localparam logic [4:0] FCR_IDX_ALIAS = 5'h1c;
    localparam logic [4:0] FCR_IDX_FULL = 5'h1f;

    // ----------------------------------------------------------------
    // Full register field positions
    // ----------------------------------------------------------------
    localparam int FCR_CC_HI = 31;
    localparam int FCR_CC_LO = 25;
    localparam int FCR_FLUSH_ZERO = 24;
    localparam int FCR_CC0 = 23;
    localparam int FCR_FLUSH_OVR = 22;
    localparam int FCR_FLUSH_NEAR = 21;
    localparam int FCR_FUSED = 20;
    localparam int FCR_ABS_NAN = 19;
    localparam int FCR_NAN_ENC = 18;
    localparam int FCR_CAUSE_HI = 17;
    localparam int FCR_CAUSE_LO = 12;
    localparam int FCR_EN_HI = 11;
    localparam int FCR_EN_LO = 7;
    localparam int FCR_FLAG_HI = 6;
    localparam int FCR_FLAG_LO = 2;
    localparam int FCR_RND_HI = 1;
    localparam int FCR_RND_LO = 0;

    // ----------------------------------------------------------------
    // Alias register field positions
    // ----------------------------------------------------------------
    localparam int FCR_A_FLUSH_ZERO = 2;

    // ----------------------------------------------------------------
    // Fixed compliance values and reset values
    // ----------------------------------------------------------------
    localparam logic FCR_FUSED_VAL = 1'b0;
    localparam logic FCR_ABS_NAN_VAL = 1'b1;
    localparam logic FCR_NAN_ENC_VAL = 1'b1;
    localparam logic [4:0] FCR_EN_RST = 5'h00;
    localparam logic FCR_FZ_RST = 1'b0;
    localparam logic [1:0] FCR_RND_RST = 2'h0;
    localparam logic [31:0] FCR_ZERO32 = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    // Exception order, most significant first: unimpl, invalid,
    // divide-by-zero, overflow, underflow, inexact.
    localparam int FCR_E_UNIMPL = 5;

    typedef enum logic [1:0]
    {
        FCR_RND_NEAREST = 2'b00,
        FCR_RND_ZERO = 2'b01,
        FCR_RND_PLUS = 2'b10,
        FCR_RND_MINUS = 2'b11
    } fcr_round_t;

endpackage

// file: core/fcr_ctl_if.sv
// Interface carrying the control fields from the register bank to the trap unit.
`timescale 1ns/1ps
interface fcr_ctl_if;
    logic [5:0] cause;
    logic [4:0] enables;
    logic trap;

    modport bank
    (
        output cause,
        output enables,
        input trap
    );

    modport trapu
    (
        input cause,
        input enables,
        output trap
    );
endinterface

// file: core/fcr_trap_unit.sv
// Trap decision from cause and enable bits.
`timescale 1ns/1ps
module fcr_trap_unit
    import fcr_pkg::*;
(
    fcr_ctl_if.trapu ctl
);

    logic [5:0] en_ext;

    // Unimplemented-operation cause has no enable; it always traps.
    assign en_ext = {1'b1, ctl.enables};

    // The trap follows any cause bit whose enable is on.
    assign ctl.trap = |(ctl.cause & en_ext);

endmodule

// file: test/fcr_regs_checker.sv
// Concurrent checks on the ports of the register bank.
`timescale 1ns/1ps
module fcr_regs_checker
    import fcr_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    input wire logic CLK_EN,
    input wire logic CP_ENABLE,
    input wire logic CTL_WR,
    input wire logic [4:0] CTL_IDX,
    input wire logic [31:0] CTL_WDATA,
    input wire logic [4:0] CTL_RIDX,
    input wire logic [31:0] CTL_RDATA,
    input wire logic CTL_DENIED,
    input wire logic ARITH_DONE,
    input wire logic [5:0] ARITH_EXC,
    input wire logic CMP_WR,
    input wire logic [2:0] CMP_SEL,
    input wire logic CMP_RESULT,
    input wire logic [7:0] COMPARE_CONDITION_CODES,
    input wire logic FLUSH_TO_ZERO,
    input wire logic FLUSH_OVERRIDE,
    input wire logic FLUSH_NEAREST,
    input wire logic FUSED_MADD_MODE,
    input wire logic [1:0] ROUND_SELECT,
    input wire logic FP_TRAP
);
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (SYS_RST);
    logic ok;
    assign ok = CLK_EN && CP_ENABLE;

    fused_fixed_a:
        assert property (FUSED_MADD_MODE == 1'b0) else $error("fused set");
    alias_zero_a:
        assert property (ok && CTL_RIDX == FCR_IDX_ALIAS |=>
            CTL_RDATA[31:12] == 20'h0 && CTL_RDATA[6:3] == 4'h0)
            else $error("alias unused bits set");
    fixed_bits_a:
        assert property (ok && CTL_RIDX == FCR_IDX_FULL |=>
            CTL_RDATA[20:18] == 3'h3) else $error("fixed bits wrong");
    access_flag_a:
        assert property (CLK_EN |=> CTL_DENIED == !$past(CP_ENABLE))
            else $error("denied flag wrong");
    alias_write_a:
        assert property (ok && CTL_WR && CTL_IDX == FCR_IDX_ALIAS |=>
            ROUND_SELECT == $past(CTL_WDATA[1:0]) &&
            FLUSH_TO_ZERO == $past(CTL_WDATA[2])) else $error("alias write");
    full_write_a:
        assert property (ok && CTL_WR && CTL_IDX == FCR_IDX_FULL |=>
            FLUSH_TO_ZERO == $past(CTL_WDATA[24]) &&
            {FLUSH_OVERRIDE, FLUSH_NEAREST} == $past(CTL_WDATA[22:21]))
            else $error("full write");
    compare_code_a:
        assert property (CLK_EN && CMP_WR |=>
            COMPARE_CONDITION_CODES[$past(CMP_SEL)] == $past(CMP_RESULT))
            else $error("compare code");
    unimpl_trap_a:
        assert property (CLK_EN && ARITH_DONE && ARITH_EXC[5] |=> FP_TRAP)
            else $error("unimplemented no trap");
endmodule
bind fcr_regs fcr_regs_checker chk (.*);

// file: test/fcr_core_model.sv
// Core-side model that issues control register moves.
`timescale 1ns/1ps
module fcr_core_model
(
    input wire logic ref_clk,
    output logic cp_enable,
    output logic ctl_wr,
    output logic [4:0] ctl_idx,
    output logic [31:0] ctl_wdata,
    output logic [4:0] ctl_ridx,
    input wire logic [31:0] ctl_rdata
);
    initial
    begin
        cp_enable = 1'b1;
        ctl_wr = 1'b0;
        ctl_idx = 5'h00;
        ctl_wdata = 32'h0000_0000;
        ctl_ridx = 5'h00;
    end
    // Released data shows the inverse so stale data cannot pass as valid.
    task automatic wr(input logic [4:0] i, input logic [31:0] d);
        ctl_wr = 1'b1;
        ctl_idx = i;
        ctl_wdata = d;
        @(negedge ref_clk);
        ctl_wr = 1'b0;
        ctl_wdata = ~d;
        // An idle cycle keeps a following move from raising the strobe
        // in the same time step that lowered it.
        @(negedge ref_clk);
    endtask
    task automatic grant(input logic g);
        cp_enable = g;
    endtask
    task automatic rd(input logic [4:0] i, output logic [31:0] d);
        ctl_ridx = i;
        @(negedge ref_clk);
        d = ctl_rdata;
    endtask
endmodule

// file: test/testbench.sv
// Self-checking bench for the control register bank.
`timescale 1ns/1ps
module testbench;
    import fcr_pkg::*;
    typedef struct packed {logic w; logic [4:0] i; logic [31:0] d;
        logic [4:0] r; logic [31:0] e;} fcr_row_t;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic arith_done = 1'b0;
    logic [5:0] arith_exc = 6'h00;
    logic cmp_wr = 1'b0;
    logic [2:0] cmp_sel = 3'h0;
    logic cmp_result = 1'b0;
    logic cp_enable, ctl_wr, ctl_denied, fz, fo, fn, fused, fp_trap;
    logic [4:0] ctl_idx, ctl_ridx;
    logic [31:0] ctl_wdata, ctl_rdata, v;
    logic [7:0] codes;
    logic [1:0] round_select;
    int n_errors = 0;
    int total_checks = 0;
    fcr_row_t rows [6] = '{
        '{1'b1, 5'h1c, 32'hffff_ffff, 5'h1c, 32'h0000_0f87},
        '{1'b1, 5'h1f, 32'h0000_0000, 5'h1f, 32'h000c_0000},
        '{1'b1, 5'h1c, 32'h0000_0f86, 5'h1f, 32'h010c_0f82},
        '{1'b1, 5'h1f, 32'h00a0_0055, 5'h1f, 32'h00ac_0055},
        '{1'b0, 5'h00, 32'h0000_0000, 5'h1c, 32'h0000_0001},
        '{1'b0, 5'h00, 32'h0000_0000, 5'h05, 32'h0000_0000}};

    always #4 ref_clk = ~ref_clk;

    fcr_core_model core (.ref_clk(ref_clk), .cp_enable(cp_enable),
        .ctl_wr(ctl_wr), .ctl_idx(ctl_idx), .ctl_wdata(ctl_wdata),
        .ctl_ridx(ctl_ridx), .ctl_rdata(ctl_rdata));
    fcr_regs uut (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .CLK_EN(clk_en),
        .CP_ENABLE(cp_enable), .CTL_WR(ctl_wr), .CTL_IDX(ctl_idx),
        .CTL_WDATA(ctl_wdata), .CTL_RIDX(ctl_ridx), .CTL_RDATA(ctl_rdata),
        .CTL_DENIED(ctl_denied), .ARITH_DONE(arith_done),
        .ARITH_EXC(arith_exc), .CMP_WR(cmp_wr), .CMP_SEL(cmp_sel),
        .CMP_RESULT(cmp_result), .COMPARE_CONDITION_CODES(codes),
        .FLUSH_TO_ZERO(fz), .FLUSH_OVERRIDE(fo), .FLUSH_NEAREST(fn),
        .FUSED_MADD_MODE(fused), .ROUND_SELECT(round_select),
        .FP_TRAP(fp_trap));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic exc(input logic [5:0] e);
        arith_done = 1'b1;
        arith_exc = e;
        @(negedge ref_clk);
        arith_done = 1'b0;
        @(negedge ref_clk);
    endtask
    task automatic close_out;
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // The whole sequence needs well under a thousand cycles.
    initial
    begin
        #200000;
        n_errors++;
        close_out;
    end

    initial
    begin
        repeat (6) @(negedge ref_clk);
        chk(round_select, 2'h0);
        sys_rst = 1'b0;
        core.rd(FCR_IDX_ALIAS, v);
        chk(v, 32'h0);
        foreach (rows[k])
        begin
            if (rows[k].w)
                core.wr(rows[k].i, rows[k].d);
            core.rd(rows[k].r, v);
            chk(v, rows[k].e);
        end
        chk({fz, fo, fn, fused}, 32'h2);
        for (int m = 0; m < 4; m++)
        begin
            core.wr(FCR_IDX_ALIAS, 32'(m));
            chk(round_select, fcr_round_t'(m));
        end
        core.grant(1'b0);
        core.wr(FCR_IDX_ALIAS, 32'h0);
        core.rd(FCR_IDX_ALIAS, v);
        chk(v, 32'h0);
        chk(ctl_denied, 1'b1);
        core.grant(1'b1);
        core.rd(FCR_IDX_ALIAS, v);
        chk(v, 32'h3);
        core.wr(FCR_IDX_FULL, 32'h0000_0800);
        exc(6'h10);
        chk(fp_trap, 1'b1);
        exc(6'h01);
        chk(fp_trap, 1'b0);
        core.rd(FCR_IDX_FULL, v);
        chk(v, 32'h000c_1804);
        exc(6'h20);
        chk(fp_trap, 1'b1);
        core.wr(FCR_IDX_FULL, 32'h0000_1080);
        chk(fp_trap, 1'b1);
        for (int m = 0; m < 8; m++)
        begin
            cmp_wr = 1'b1;
            cmp_sel = 3'(m);
            cmp_result = m[0];
            @(negedge ref_clk);
        end
        cmp_wr = 1'b0;
        chk(codes, 8'haa);
        core.rd(FCR_IDX_FULL, v);
        chk({v[31:25], v[23]}, 8'haa);
        sys_rst = 1'b1;
        @(negedge ref_clk);
        sys_rst = 1'b0;
        core.rd(FCR_IDX_ALIAS, v);
        chk(v, 32'h0);
        close_out;
    end
endmodule
